/* common/sgc_consts.vh */
// Notes on behaviour
// RULE_01: key 0x04AD always permits writing the bus address.
// RULE_02: key 0x44AD permits it only while general pin 0 is high.
// RULE_03: key 0x84AD permits it only while general pin 1 is high.
// RULE_04: key 0xC4AD permits it only while both general pins are high.
// RULE_05: soft reset bit 0 set resets the device; the bit self-clears.
// RULE_06: reset write is acknowledged first, then standby with defaults.
// RULE_07: mode bits 1..0: 0 standby, 1 program, 2 normal; reset standby.
// RULE_08: slot bit 13 picks block sum (0) or block average (1) readback.
// RULE_09: slot bit 12 low lets the FIFO overwrite its oldest entries.
// RULE_10: bit 12 high (default) keeps new data only while not full.
// RULE_11: pin select 0x10 drives low, 0x11 high, 0x13 the 32 kHz clock.
// RULE_12: the host writes zeros to the reserved soft reset bits.
// RULE_13: any other key value leaves address writes without effect.
`ifndef SGC_CONSTS_VH
`define SGC_CONSTS_VH
// ==========================================================
// register offsets
`define SGC_ADDR_PINCFG 8'h0B
`define SGC_ADDR_BUSADDR 8'h09
`define SGC_ADDR_KEY 8'h0D
`define SGC_ADDR_SWRST 8'h0F
`define SGC_ADDR_MODE 8'h10
`define SGC_ADDR_SLOT 8'h11
// ==========================================================
// keys, fields and reset values
`define SGC_KEY_ALWAYS 16'h04AD
`define SGC_KEY_PIN0 16'h44AD
`define SGC_KEY_PIN1 16'h84AD
`define SGC_KEY_BOTH 16'hC4AD
`define SGC_KEY_RST 16'h0000
`define SGC_MODE_RST 16'h0000
`define SGC_SLOT_RST 16'h1000
`define SGC_PINCFG_RST 16'h0000
`define SGC_BUSADDR_RST 16'h0064
`define SGC_BIT_AVG 13
`define SGC_BIT_FULLPOL 12
`define SGC_BIT_SWRST 0
`define SGC_MODE_MSB 1
`define SGC_SEL_MSB 12
`define SGC_SEL_LSB 8
`define SGC_SEL_LOW 5'h10
`define SGC_SEL_HIGH 5'h11
`define SGC_SEL_OSC 5'h13
`define SGC_ZERO16 16'h0000
`define SGC_MODE_LSB 0
`define SGC_BUSADDR_MSB 6
`define SGC_BUSADDR_LSB 0
`define SGC_SWRST_RSVD 15'h0000
`endif

/* hw/sgc_global_regs.v */
`timescale 1ns/100ps
`include "sgc_consts.vh"
module sgc_global_regs (
   input wire clk,
   input wire rst_n,
   input wire regWrite,
   input wire regRead,
   input wire [7:0] regAddr,
   input wire [15:0] regWdata,
   input wire writeDone,
   input wire generalPin0,
   input wire generalPin1,
   input wire osc32k,
   input wire fifoFull,
   input wire fifoPushReq,
   output reg [15:0] regRdata,
   output wire [1:0] operatingMode,
   output wire extendedReadbackFormat,
   output wire fifoFullPolicy,
   output wire fifoPushEnable,
   output wire fifoDropOldest,
   output wire [6:0] busAddress,
   output wire softResetActive,
   output wire generalPinOut
);

   // ==========================================================
   // soft reset sequencer states, one-hot

   localparam [2:0] ST_IDLE = 3'h1;
   localparam [2:0] ST_PEND = 3'h2;
   localparam [2:0] ST_FIRE = 3'h4;

   // ==========================================================
   // stored register words and their next values

   reg [15:0] unlockKey_reg;
   reg [15:0] unlockKey_next;
   reg [15:0] modeWord_reg;
   reg [15:0] modeWord_next;
   reg [15:0] slotWord_reg;
   reg [15:0] slotWord_next;
   reg [15:0] pinCfg_reg;
   reg [15:0] pinCfg_next;
   reg [15:0] busAddr_reg;
   reg [15:0] busAddr_next;
   reg [15:0] readData_next;

   // ==========================================================
   // sequencer state

   reg [2:0] rstState_reg;
   reg [2:0] rstState_next;
   reg softReset_reg;
   reg softReset_next;

   // ==========================================================
   // decode nets

   wire keyWrite;
   wire modeWrite;
   wire slotWrite;
   wire pinCfgWrite;
   wire busAddrWrite;
   wire swRstWrite;
   wire swRstPending;
   wire addrUnlock;
   wire [4:0] pinSel;

   // ==========================================================
   // helpers

   // register index compare, shared by write decode
   function hit;
      input [7:0] a;
      input [7:0] target;
      begin
         hit = (a == target);
      end
   endfunction

   // one unlock code, qualified by the pin level it needs
   function keyMatch;
      input [15:0] key;
      input [15:0] code;
      input qualifier;
      begin
         keyMatch = (key == code) & qualifier;
      end
   endfunction

   // pin output select; unsupported codes drive low, the safe idle level
   function pinLevel;
      input [4:0] sel;
      input osc;
      begin
         case (sel)
            `SGC_SEL_LOW: begin
               pinLevel = 1'b0; //RULE_11
            end
            `SGC_SEL_HIGH: begin
               pinLevel = 1'b1; //RULE_11
            end
            `SGC_SEL_OSC: begin
               pinLevel = osc; //RULE_11
            end
            default: begin
               pinLevel = 1'b0;
            end
         endcase
      end
   endfunction

   // ==========================================================
   // write decode

   assign keyWrite = regWrite & hit(regAddr, `SGC_ADDR_KEY);
   assign modeWrite = regWrite & hit(regAddr, `SGC_ADDR_MODE);
   assign slotWrite = regWrite & hit(regAddr, `SGC_ADDR_SLOT);
   assign pinCfgWrite = regWrite & hit(regAddr, `SGC_ADDR_PINCFG);
   assign swRstWrite = regWrite & hit(regAddr, `SGC_ADDR_SWRST) &
      regWdata[`SGC_BIT_SWRST]; //RULE_05

   // ==========================================================
   // address unlock decode
   // the key is compared whole, so a near miss never opens the address

   assign addrUnlock =
      keyMatch(unlockKey_reg, `SGC_KEY_ALWAYS, 1'b1) | //RULE_01
      keyMatch(unlockKey_reg, `SGC_KEY_PIN0, generalPin0) | //RULE_02
      keyMatch(unlockKey_reg, `SGC_KEY_PIN1, generalPin1) | //RULE_03
      keyMatch(unlockKey_reg, `SGC_KEY_BOTH,
         generalPin0 & generalPin1); //RULE_04
   assign busAddrWrite = regWrite & hit(regAddr, `SGC_ADDR_BUSADDR) &
      addrUnlock; //RULE_13

   // ==========================================================
   // soft reset sequencer
   // the request waits for the end of the host transaction so the
   // write is acknowledged before the registers fall back to defaults

   always @* begin
      rstState_next = rstState_reg;
      softReset_next = 1'b0;
      case (rstState_reg)
         ST_IDLE: begin
            if (swRstWrite) begin
               rstState_next = ST_PEND; //RULE_05
            end
         end
         ST_PEND: begin
            if (writeDone) begin
               rstState_next = ST_FIRE;
               softReset_next = 1'b1; //RULE_06
            end
         end
         ST_FIRE: begin
            // a fresh request in the reset cycle is kept, not lost
            if (swRstWrite) begin
               rstState_next = ST_PEND; //RULE_05
            end else begin
               rstState_next = ST_IDLE;
            end
         end
         default: begin
            rstState_next = ST_IDLE;
         end
      endcase
   end

   assign swRstPending = (rstState_reg == ST_PEND);
   assign softResetActive = softReset_reg;

   // ==========================================================
   // key register

   always @* begin
      unlockKey_next = unlockKey_reg;
      if (softReset_reg) begin
         unlockKey_next = `SGC_KEY_RST; //RULE_06
      end else if (keyWrite) begin
         unlockKey_next = regWdata;
      end
   end

   // ==========================================================
   // mode register

   always @* begin
      modeWord_next = modeWord_reg;
      if (softReset_reg) begin
         modeWord_next = `SGC_MODE_RST; //RULE_06
      end else if (modeWrite) begin
         modeWord_next = regWdata; //RULE_07
      end
   end

   // ==========================================================
   // slot and FIFO configuration register

   always @* begin
      slotWord_next = slotWord_reg;
      if (softReset_reg) begin
         slotWord_next = `SGC_SLOT_RST; //RULE_06
      end else if (slotWrite) begin
         slotWord_next = regWdata;
      end
   end

   // ==========================================================
   // pin select register

   always @* begin
      pinCfg_next = pinCfg_reg;
      if (softReset_reg) begin
         pinCfg_next = `SGC_PINCFG_RST; //RULE_06
      end else if (pinCfgWrite) begin
         pinCfg_next = regWdata;
      end
   end

   // ==========================================================
   // bus address register
   // a locked write is dropped silently; the host sees no error

   always @* begin
      busAddr_next = busAddr_reg;
      if (softReset_reg) begin
         busAddr_next = `SGC_BUSADDR_RST; //RULE_06
      end else if (busAddrWrite) begin
         busAddr_next = regWdata; //RULE_01
      end
   end

   // ==========================================================
   // readback
   // the soft reset bit reads its pending state; read data holds
   // until the next read so the host may sample it late

   always @* begin
      readData_next = regRdata;
      if (regRead) begin
         case (regAddr)
            `SGC_ADDR_KEY: begin
               readData_next = unlockKey_reg;
            end
            `SGC_ADDR_SWRST: begin
               readData_next = {`SGC_SWRST_RSVD, swRstPending}; //RULE_05
            end
            `SGC_ADDR_MODE: begin
               readData_next = modeWord_reg;
            end
            `SGC_ADDR_SLOT: begin
               readData_next = slotWord_reg;
            end
            `SGC_ADDR_PINCFG: begin
               readData_next = pinCfg_reg;
            end
            `SGC_ADDR_BUSADDR: begin
               readData_next = busAddr_reg;
            end
            default: begin
               readData_next = `SGC_ZERO16;
            end
         endcase
      end
   end

   // ==========================================================
   // flip-flops

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         unlockKey_reg <= `SGC_KEY_RST;
         modeWord_reg <= `SGC_MODE_RST;
         slotWord_reg <= `SGC_SLOT_RST;
         pinCfg_reg <= `SGC_PINCFG_RST;
         busAddr_reg <= `SGC_BUSADDR_RST;
         rstState_reg <= ST_IDLE;
         softReset_reg <= 1'b0;
         regRdata <= `SGC_ZERO16;
      end else begin
         unlockKey_reg <= unlockKey_next;
         modeWord_reg <= modeWord_next;
         slotWord_reg <= slotWord_next;
         pinCfg_reg <= pinCfg_next;
         busAddr_reg <= busAddr_next;
         rstState_reg <= rstState_next;
         softReset_reg <= softReset_next;
         regRdata <= readData_next;
      end
   end

   // ==========================================================
   // block outputs
   // push enable and drop are combinational so the FIFO can act
   // in the same cycle as its request

   assign operatingMode =
      modeWord_reg[`SGC_MODE_MSB:`SGC_MODE_LSB]; //RULE_07
   assign extendedReadbackFormat = slotWord_reg[`SGC_BIT_AVG]; //RULE_08
   assign fifoFullPolicy = slotWord_reg[`SGC_BIT_FULLPOL]; //RULE_10
   assign fifoPushEnable =
      fifoPushReq & (~fifoFullPolicy | ~fifoFull); //RULE_10
   assign fifoDropOldest =
      fifoPushReq & fifoFull & ~fifoFullPolicy; //RULE_09
   assign busAddress =
      busAddr_reg[`SGC_BUSADDR_MSB:`SGC_BUSADDR_LSB];

   // ==========================================================
   // general pin output
   // the oscillator level passes straight through, so it carries
   // no extra register delay

   assign pinSel = pinCfg_reg[`SGC_SEL_MSB:`SGC_SEL_LSB];
   assign generalPinOut = pinLevel(pinSel, osc32k); //RULE_11

endmodule

/* verification/sgc_host_model.sv */
`timescale 1ns/100ps
module sgc_host_model (
   input wire clk,
   input wire [15:0] regRdata,
   output reg regWrite = 1'b0,
   output reg regRead = 1'b0,
   output reg writeDone = 1'b0,
   output reg [7:0] regAddr = 8'h00,
   output reg [15:0] regWdata = 16'h0000
);
   // each write closes with the done pulse, as a bus ack would
   task wr(input [7:0] a, input [15:0] d);
      @(negedge clk) {regWrite, regAddr, regWdata} <= {1'b1, a, d};
      @(negedge clk) {regWrite, writeDone} <= 2'b01;
      @(negedge clk) writeDone <= 1'b0;
   endtask
   task rd(input [7:0] a, output [15:0] d);
      @(negedge clk) {regRead, regAddr} <= {1'b1, a};
      @(negedge clk) regRead <= 1'b0;
      d = regRdata;
   endtask
endmodule

/* verification/sgc_global_regs_assertions.sv */
`timescale 1ns/100ps
module sgc_global_regs_assertions (
   input wire clk,
   input wire rst_n,
   input wire regWrite,
   input wire writeDone,
   input wire fifoFull,
   input wire fifoPushReq,
   input wire softResetActive,
   input wire fifoFullPolicy,
   input wire fifoPushEnable,
   input wire fifoDropOldest,
   input wire extendedReadbackFormat,
   input wire [7:0] regAddr,
   input wire [15:0] regWdata,
   input wire [1:0] operatingMode,
   input wire [6:0] busAddress
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   wire wSlot = regWrite && regAddr == 8'h11;
   // shadow of the last key written, cleared with the device's reset
   reg [15:0] keySeen = 16'h0000;
   wire keyKnown = keySeen == 16'h04AD || keySeen == 16'h44AD ||
      keySeen == 16'h84AD || keySeen == 16'hC4AD;
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) keySeen <= 16'h0000;
      else if (softResetActive) keySeen <= 16'h0000;
      else if (regWrite && regAddr == 8'h0D) keySeen <= regWdata;
   end
   sequence sDefaults;
      !softResetActive && operatingMode == 2'h0 && busAddress == 7'h64;
   endsequence
   AST_MODE: assert property (regWrite && regAddr == 8'h10 |=>
      operatingMode == $past(regWdata[1:0])) else $error("mode");
   AST_AVG: assert property (wSlot |=>
      extendedReadbackFormat == $past(regWdata[13])) else $error("avg");
   AST_POL: assert property (wSlot |=>
      fifoFullPolicy == $past(regWdata[12])) else $error("policy");
   AST_WRAP: assert property (
      fifoDropOldest == (fifoPushReq && fifoFull && !fifoFullPolicy))
      else $error("wrap");
   AST_TAKE: assert property (
      fifoPushReq && !fifoFull |-> fifoPushEnable) else $error("take");
   AST_UNLK: assert property (
      regWrite && regAddr == 8'h09 && !keyKnown && !softResetActive |=>
      $stable(busAddress)) else $error("unlock");
   AST_KEEP: assert property (
      fifoFull && fifoFullPolicy |-> !fifoPushEnable) else $error("keep");
   AST_LOCK: assert property (
      !(regWrite && regAddr == 8'h09 || softResetActive) |=>
      $stable(busAddress)) else $error("address");
   AST_RST: assert property (softResetActive |=> sDefaults)
      else $error("defaults");
   AST_ACK: assert property (softResetActive |-> $past(writeDone))
      else $error("early");
endmodule
bind sgc_global_regs sgc_global_regs_assertions u_chk (.*);

/* verification/sgc_global_regs_test.sv */
`timescale 1ns/100ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
   num_errors++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module sgc_global_regs_test;
   reg clk = 1'b0, rst_n = 1'b0, generalPin0 = 1'b0, generalPin1 = 1'b0;
   reg osc32k = 1'b1, fifoFull = 1'b0, fifoPushReq = 1'b1;
   wire regWrite, regRead, writeDone, extendedReadbackFormat, fifoFullPolicy;
   wire fifoPushEnable, fifoDropOldest, softResetActive, generalPinOut;
   wire [7:0] regAddr;
   wire [15:0] regWdata, regRdata;
   wire [1:0] operatingMode;
   wire [6:0] busAddress;
   reg [15:0] d;
   reg [6:0] ex = 7'h64;
   integer num_errors = 0, total_checks = 0, k;
   sgc_global_regs u_sgc_global_regs (.*);
   sgc_host_model host (.*);
   always #20 clk = ~clk;
   task t_cfg;
      host.rd(8'h11, d);
      `CHK("slot", 16'h1000, d)
      for (k = 1; k < 3; k++) host.wr(8'h10, 16'(k));
      host.rd(8'h10, d);
      `CHK("mode", 16'h0002, d)
      `CHK("opmode", 2'h2, operatingMode)
      fifoFull = 1'b1;
      #1;
      `CHK("keep", 1'b0, fifoPushEnable)
      host.wr(8'h11, 16'h2000);
      `CHK("avg", 1'b1, extendedReadbackFormat)
      `CHK("wrap", 1'b1, fifoDropOldest)
      fifoPushReq = 1'b0;
      #1;
      `CHK("idle", 1'b0, fifoDropOldest)
      fifoPushReq = 1'b1;
      host.wr(8'h11, 16'h1000);
      `CHK("full", 1'b0, fifoPushEnable)
      fifoFull = 1'b0;
      #1;
      `CHK("take", 1'b1, fifoPushEnable)
      for (k = 16; k < 20; k++) begin
         host.wr(8'h0B, 16'(k << 8));
         `CHK("pin", k[0], generalPinOut)
      end
      osc32k = 1'b0;
      #1;
      `CHK("osc", 1'b0, generalPinOut)
   endtask
   task t_unlock;
      for (k = 0; k < 20; k++) begin
         {generalPin1, generalPin0} = k[1:0];
         host.wr(8'h0D, k > 15 ? 16'h04AC : {k[3:2], 14'h04AD});
         if (k < 16 && (!k[2] || k[0]) && (!k[3] || k[1])) ex = 7'(k + 1);
         host.wr(8'h09, 16'(k + 1));
         `CHK("adr", ex, busAddress)
      end
   endtask
   task t_rst;
      host.wr(8'h0F, 16'h0001);
      `CHK("pulse", 1'b1, softResetActive)
      host.rd(8'h0F, d);
      `CHK("clear", 16'h0000, d)
      `CHK("mode0", 2'h0, operatingMode)
      `CHK("adr0", 7'h64, busAddress)
   endtask
   task conclude;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      #480 rst_n = 1'b1;
      t_cfg;
      t_unlock;
      t_rst;
      conclude;
   end
   initial begin
      #80000 num_errors++;
      conclude;
   end
endmodule
